// *** hdl/pmat_pkg.sv ***
package pmat_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CFG    = 8'h80;
	localparam logic [7:0] IDX_TOP    = 8'h81;
	localparam logic [7:0] IDX_MIRROR = 8'h86;
	localparam logic [7:0] IDX_LOAD   = 8'h88;
	localparam logic [7:0] IDX_CTRL   = 8'h89;
	localparam logic [7:0] IDX_TWIN   = 8'hF7;
	localparam int         ADDR_W     = 12;

	// Reset values
	localparam logic [7:0] RST_LOAD   = 8'h00;
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [7:0] RST_CFG    = 8'h00;
	localparam logic [7:0] RST_MIRROR = 8'h00;

	// Configuration register fields
	localparam int CFG_TIMER_EN = 0;
	localparam int CFG_WIDTH16  = 1;
	localparam int CFG_THERM_EN = 2;
	localparam int CFG_ACPI_EN  = 3;
	localparam int CFG_CODEC_EN = 4;
	localparam int CFG_ROUTE    = 5;

	// Timer control fields
	localparam int CTRL_MS_BASE = 7;
	localparam int CTRL_KBD     = 3;
	localparam int RETRIG_N     = 7;

	// Mirror fields
	localparam int MIR_GPIO   = 7;
	localparam int MIR_THERM  = 6;
	localparam int MIR_SUPIO  = 3;
	localparam int MIR_CODEC  = 2;
	localparam int MIR_RTC    = 1;
	localparam int MIR_ACPI   = 0;
	localparam logic [7:0] MIR_USED = 8'hCF;

	// Top status fields
	localparam int TOP_EVENT  = 0;
	localparam int TOP_TIMER1 = 9;
	localparam int TOP_T1_L2  = 16;

	// Timebase
	localparam int CLK_PERIOD_NS = 25;
	localparam int TICK_MS_NS    = 1000000;
	localparam int MS_CYCLES     = (TICK_MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_SEC_MS   = 1000;
	localparam int GPIO_N        = 16;
endpackage

// *** hdl/pmat_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Operation
// RL1: Reading the status mirror leaves every status bit unchanged.
// RL2: Reading the twin clears flagged second and top level status, bit 7 excepted.
// RL3: Bit 7 flags an interrupt from an enabled GPIO transition.
// RL4: GPIO events count only with routing bit 0 and GPIO set as input.
// RL5: Bit 6 flags thermal alarm assertion, only when its enable is set.
// RL6: Bits 5 and 4 are reserved and read zero.
// RL7: Bit 3 flags a power-up request from the super-I/O unit.
// RL8: Bit 2 flags a codec input rising edge, only when enabled.
// RL9: Bit 1 flags RTC alarm, only in 3V suspend with routing bit 0.
// RL10: Bit 0 flags ACPI timer MSB toggle, only when enabled.
// RL11: Load register holds timer 1 value; a control bit selects 8 or 16 bits. The code selects with configuration bit 1 instead.
// RL12: Load value is copied into timer 1 when its enable is set.
// RL13: While enabled, selected activity events reload timer 1.
// RL14: Timer 1 decrements once per millisecond or second tick.
// RL15: Expiry raises the interrupt, sets top bit 9 and second-level bit 0.
// RL16: After expiry timer stays stopped until re-enabled or reloaded by write.
// RL17: Control bit 7 picks timebase: 0 seconds, 1 milliseconds.
// RL18: Control bits 6 to 4 enable reload on user range three, two, one access.
// RL19: Control bit 3 enables reload on keyboard or mouse activity.
// RL20: In 16-bit mode the start count is the load value shifted left eight.
// RL21: Disabled timer neither counts, expires nor reacts to reloads.
module pmat_top
	import pmat_pkg::*;
#(
	parameter int MS_TICK_CYCLES = MS_CYCLES,
	parameter int GPIO_LINES     = GPIO_N
)
(
	// Clock, reset, enable
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	// APB slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_W-1:0]     paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Pins, asynchronous
	input  wire logic                  thermal_alarm_n,
	input  wire logic                  codec_sdata_in,
	input  wire logic                  rtc_alarm_irq_n,
	// Same-clock event sources
	input  wire logic                  powerup_request,
	input  wire logic                  acpi_timer_msb,
	input  wire logic                  suspend_3v,
	input  wire logic [GPIO_LINES-1:0] gpio_transition,
	input  wire logic [GPIO_LINES-1:0] gpio_pme_enable,
	input  wire logic [GPIO_LINES-1:0] gpio_dir_input,
	input  wire logic                  gpio_third_clear,
	input  wire logic [RETRIG_N-1:0]   retrigger_activity,
	// Interrupt and top-level status
	output logic                       system_mgmt_interrupt,
	output logic                       top_event_status,
	output logic                       top_timer1_status
);

	localparam int MSW = (MS_TICK_CYCLES > 1) ? $clog2(MS_TICK_CYCLES) : 1;

	generate
		if (MS_TICK_CYCLES < 2 || GPIO_LINES < 1)
		begin : g_check
			$error("pmat_top: MS_TICK_CYCLES must be >= 2 and GPIO_LINES >= 1");
		end
	endgenerate

	logic [7:0]   load;
	logic [7:0]   ctrl;
	logic [7:0]   cfg;
	logic [7:0]   mirror;
	logic         top_t1_l2;
	logic [15:0]  count;
	logic         running;
	logic         en_prev;
	logic [2:0]   sync1;
	logic [2:0]   sync2;
	logic [2:0]   pin_prev;
	logic         msb_prev;
	logic [MSW-1:0] ms_cnt;
	logic [9:0]   sec_cnt;

	// APB decode: pready is always high, so every access takes one access cycle
	logic [7:0] idx;
	logic       setup;
	logic       access;
	logic       wr_en;
	logic       rd_en;
	logic       mapped;
	assign idx    = paddr[9:2];
	assign setup  = ce & psel & ~penable;
	assign access = ce & psel & penable;
	assign wr_en  = access & pwrite;
	assign rd_en  = access & ~pwrite;
	assign mapped = (idx == IDX_CFG) | (idx == IDX_TOP) | (idx == IDX_MIRROR) |
			(idx == IDX_LOAD) | (idx == IDX_CTRL) | (idx == IDX_TWIN);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Read data is captured in setup so it can serve as the clear mask in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup && !pwrite)
		begin
			case (idx)
				IDX_CFG:    prdata <= {24'h00_0000, cfg};
				IDX_TOP:    prdata <= {15'h0000, top_t1_l2, 6'h00, top_timer1_status,
						8'h00, top_event_status};
				IDX_MIRROR: prdata <= {24'h00_0000, mirror & MIR_USED}; // RL6
				IDX_TWIN:   prdata <= {24'h00_0000, mirror & MIR_USED}; // RL6
				IDX_LOAD:   prdata <= {24'h00_0000, load};
				IDX_CTRL:   prdata <= {24'h00_0000, ctrl};
				default:    prdata <= 32'h0000_0000;
			endcase
		end
	end

	logic load_wr;
	assign load_wr = wr_en && idx == IDX_LOAD;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			load <= RST_LOAD;
			ctrl <= RST_CTRL;
			cfg  <= RST_CFG;
		end
		else if (wr_en)
		begin
			if (idx == IDX_LOAD)
				load <= pwdata[7:0]; // RL11
			if (idx == IDX_CTRL)
				ctrl <= pwdata[7:0]; // RL17
			if (idx == IDX_CFG)
				cfg <= pwdata[7:0];
		end
	end

	// Two-stage synchronisers for the pin inputs
	logic [2:0] pins;
	assign pins = {rtc_alarm_irq_n, codec_sdata_in, thermal_alarm_n};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_sync
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					sync1[gi]    <= 1'b0;
					sync2[gi]    <= 1'b0;
					pin_prev[gi] <= 1'b0;
				end
				else if (ce)
				begin
					sync1[gi]    <= pins[gi];
					sync2[gi]    <= sync1[gi];
					pin_prev[gi] <= sync2[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			msb_prev <= 1'b0;
		else if (ce)
			msb_prev <= acpi_timer_msb;
	end

	// Event detection; low-active pins start low after reset, so a pin idle
	// high yields one spurious rising edge only, never a falling one
	logic [7:0] set_vec;
	logic       gpio_hit;
	assign gpio_hit = |(gpio_transition & gpio_pme_enable & gpio_dir_input);
	always_comb
	begin
		set_vec = 8'h00;
		set_vec[MIR_GPIO]  = ce & gpio_hit & ~cfg[CFG_ROUTE]; // RL3 RL4
		set_vec[MIR_THERM] = ce & cfg[CFG_THERM_EN] & pin_prev[0] & ~sync2[0]; // RL5
		set_vec[MIR_SUPIO] = ce & powerup_request; // RL7
		set_vec[MIR_CODEC] = ce & cfg[CFG_CODEC_EN] & ~pin_prev[1] & sync2[1]; // RL8
		set_vec[MIR_RTC]   = ce & suspend_3v & ~cfg[CFG_ROUTE] &
				pin_prev[2] & ~sync2[2]; // RL9
		set_vec[MIR_ACPI]  = ce & cfg[CFG_ACPI_EN] & (msb_prev ^ acpi_timer_msb); // RL10
	end

	// Twin reads clear only bits actually returned to software, gpio_third_clear clears bit 7; a new set wins
	logic       twin_rd;
	logic       top_rd;
	logic [7:0] clr_vec;
	logic [7:0] next_mirror;
	assign twin_rd = rd_en && idx == IDX_TWIN;
	assign top_rd  = rd_en && idx == IDX_TOP;
	always_comb
	begin
		clr_vec = 8'h00;
		if (twin_rd)
			clr_vec = prdata[7:0] & MIR_USED & ~(8'h01 << MIR_GPIO); // RL1 RL2
		clr_vec[MIR_GPIO] = ce & gpio_third_clear;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mirror <= RST_MIRROR;
		else
			mirror <= next_mirror;
	end

	// Top summary follows the mirror, so it drops once every flag has gone
	assign next_mirror = ((mirror & ~clr_vec) | set_vec) & MIR_USED; // RL2 RL6

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			top_event_status <= 1'b0;
		else
			top_event_status <= |next_mirror; // RL2
	end

	// Timebase: free-running millisecond prescaler and second counter
	logic ms_tick;
	logic sec_tick;
	logic tick;
	assign ms_tick  = ce && ms_cnt == MSW'(MS_TICK_CYCLES - 1);
	assign sec_tick = ms_tick && sec_cnt == 10'(TICK_SEC_MS - 1);
	assign tick     = ctrl[CTRL_MS_BASE] ? ms_tick : sec_tick; // RL17

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt  <= '0;
			sec_cnt <= 10'h000;
		end
		else if (ce)
		begin
			ms_cnt <= ms_tick ? '0 : MSW'(ms_cnt + 1'b1);
			if (sec_tick)
				sec_cnt <= 10'h000;
			else if (ms_tick)
				sec_cnt <= 10'(sec_cnt + 10'h001);
		end
	end

	// Timer 1
	logic        en;
	logic        start_load;
	logic        reload;
	logic [7:0]  start_src;
	logic [15:0] start_val;
	logic [15:0] reg_start;
	logic        timer_expire;
	assign en         = cfg[CFG_TIMER_EN];
	assign start_src  = load_wr ? pwdata[7:0] : load;
	assign start_val  = cfg[CFG_WIDTH16] ? {start_src, 8'h00} : {8'h00, start_src}; // RL20
	assign reg_start  = cfg[CFG_WIDTH16] ? {load, 8'h00} : {8'h00, load};
	assign start_load = ce & en & (~en_prev | load_wr); // RL12 RL16
	assign reload     = ce & running & |(ctrl[RETRIG_N-1:0] & retrigger_activity); // RL13 RL18 RL19
	assign timer_expire = en & running & ~start_load & ~reload & tick &
			(count <= 16'h0001); // RL15 RL21

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			en_prev <= 1'b0;
		else if (ce)
			en_prev <= en;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count   <= 16'h0000;
			running <= 1'b0;
		end
		else if (ce)
		begin
			if (!en)
				running <= 1'b0; // RL21
			else if (start_load)
			begin
				count   <= start_val; // RL12
				running <= 1'b1;
			end
			else if (reload)
				count <= reg_start; // RL13
			else if (running && tick)
			begin
				if (count <= 16'h0001)
				begin
					count   <= 16'h0000;
					running <= 1'b0; // RL16
				end
				else
					count <= 16'(count - 16'h0001); // RL14
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			top_timer1_status <= 1'b0;
			top_t1_l2         <= 1'b0;
		end
		else if (timer_expire)
		begin
			top_timer1_status <= 1'b1; // RL15
			top_t1_l2         <= 1'b1; // RL15
		end
		else if (top_rd)
		begin
			if (prdata[TOP_TIMER1])
				top_timer1_status <= 1'b0;
			if (prdata[TOP_T1_L2])
				top_t1_l2 <= 1'b0;
		end
	end

	assign system_mgmt_interrupt = top_event_status | top_timer1_status; // RL15

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_mirror_read_keeps: assert property ( // RL1
		(rd_en && idx == IDX_MIRROR && !gpio_third_clear) |=>
		((mirror & $past(mirror)) == $past(mirror)))
		else $error("mirror read lost a status bit");
	a_twin_clears: assert property ( // RL2
		(twin_rd && set_vec == 8'h00 && !gpio_third_clear) |=>
		((mirror & $past(prdata[7:0]) & 8'h4F) == 8'h00) &&
		(mirror[MIR_GPIO] == $past(mirror[MIR_GPIO])))
		else $error("twin read did not clear as expected");
	a_gpio_flag: assert property ( // RL3
		(ce && gpio_hit && !cfg[CFG_ROUTE]) |=> mirror[MIR_GPIO] && top_event_status)
		else $error("gpio event not flagged");
	a_route_blocks: assert property ( // RL4
		cfg[CFG_ROUTE] |=> !$rose(mirror[MIR_GPIO]) && !$rose(mirror[MIR_RTC]))
		else $error("routed-away event flagged");
	a_thermal_gate: assert property ( // RL5
		!cfg[CFG_THERM_EN] |=> !$rose(mirror[MIR_THERM]))
		else $error("thermal flag set while disabled");
	a_reserved_zero: assert property ( // RL6
		(setup && !pwrite && (idx == IDX_MIRROR || idx == IDX_TWIN)) |=>
		(prdata[5:4] == 2'b00) && (mirror[5:4] == 2'b00))
		else $error("reserved mirror bits set");
	a_codec_gate: assert property ( // RL8
		!cfg[CFG_CODEC_EN] |=> !$rose(mirror[MIR_CODEC]))
		else $error("codec flag set while disabled");
	a_rtc_gate: assert property ( // RL9
		!suspend_3v |=> !$rose(mirror[MIR_RTC]))
		else $error("rtc flag set outside suspend");
	a_acpi_gate: assert property ( // RL10
		!cfg[CFG_ACPI_EN] |=> !$rose(mirror[MIR_ACPI]))
		else $error("acpi flag set while disabled");
	a_enable_loads: assert property ( // RL12
		(ce && en && !en_prev && !load_wr) |=> running && count == $past(reg_start))
		else $error("enable did not load timer");
	a_tick_decrement: assert property ( // RL14
		(ce && en && running && tick && !reload && !start_load && count > 16'h0001)
		|=> count == 16'($past(count) - 16'h0001))
		else $error("timer did not decrement on tick");
	a_expire_sets: assert property ( // RL15
		timer_expire |=> top_timer1_status && top_t1_l2 && system_mgmt_interrupt && !running)
		else $error("expiry did not set status");
	a_stopped_after: assert property ( // RL16
		(!running && !start_load) |=> !running && $stable(count))
		else $error("stopped timer moved");
	a_disabled_idle: assert property ( // RL21
		(ce && !en) |-> !timer_expire ##1 !running)
		else $error("disabled timer active");

endmodule

`default_nettype wire

// *** tb/pmat_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h expected %h", $time, (a), (b)); end end
module pmat_top_test
	import pmat_pkg::*;
;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic        thermal_alarm_n, codec_sdata_in, rtc_alarm_irq_n, e;
	logic        powerup_request, acpi_timer_msb, suspend_3v, gpio_third_clear;
	logic [15:0] gpio_transition, gpio_pme_enable, gpio_dir_input;
	logic [6:0]  retrigger_activity;
	logic        system_mgmt_interrupt, top_event_status, top_timer1_status;
	int          failures, check_count, n, i, j, k;
	int          ev [5] = '{0, 1, 2, 3, 6};

	// Short tick keeps the 16-bit and seconds runs within a few thousand cycles
	pmat_top #(.MS_TICK_CYCLES(4), .GPIO_LINES(16)) dut (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .thermal_alarm_n,
		.codec_sdata_in, .rtc_alarm_irq_n, .powerup_request, .acpi_timer_msb, .suspend_3v,
		.gpio_transition, .gpio_pme_enable, .gpio_dir_input, .gpio_third_clear,
		.retrigger_activity, .system_mgmt_interrupt, .top_event_status, .top_timer1_status);

	initial
	begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic give_verdict();
		$display("Counts: %0d comparisons, %0d failures", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int c;
		@(posedge pclk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'h1;
		c = 0;
		do
		begin
			@(posedge pclk);
			c++;
		end
		while (pready !== 1'h1 && c < 16);
		if (pready !== 1'h1)
		begin
			$display("[ERR] %0t bus access timed out", $time);
			failures++;
			give_verdict();
		end
		r = prdata;
		e = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [31:0] x);
		apb(1'h0, idx, 8'h00);
		`CHK(r, x)
	endtask

	// Pins are restored after the sync delay so the next event sees a fresh edge
	task automatic fire(input int t);
		@(posedge pclk);
		case (t)
			0: acpi_timer_msb <= ~acpi_timer_msb;
			1: rtc_alarm_irq_n <= 1'h0;
			2: codec_sdata_in <= 1'h1;
			3: powerup_request <= 1'h1;
			6: thermal_alarm_n <= 1'h0;
			default: gpio_transition <= 16'hFFFF;
		endcase
		@(posedge pclk);
		powerup_request <= 1'h0;
		gpio_transition <= 16'h0000;
		repeat (8) @(posedge pclk);
		rtc_alarm_irq_n <= 1'h1;
		codec_sdata_in  <= 1'h0;
		thermal_alarm_n <= 1'h1;
		repeat (8) @(posedge pclk);
	endtask

	task automatic tmr(input logic [7:0] ctl, input logic [7:0] ld, input logic [7:0] cf);
		apb(1'h1, IDX_CFG, 8'h00);
		apb(1'h0, IDX_TOP, 8'h00);
		apb(1'h1, IDX_CTRL, ctl);
		apb(1'h1, IDX_LOAD, ld);
		apb(1'h1, IDX_CFG, cf);
	endtask

	task automatic wait_exp(input int lim);
		n = 0;
		while (top_timer1_status !== 1'h1 && n < lim)
		begin
			@(negedge pclk);
			n++;
		end
	endtask

	initial
	begin
		repeat (60000) @(posedge pclk);
		$display("[ERR] %0t watchdog expired", $time);
		failures++;
		give_verdict();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{powerup_request, acpi_timer_msb, suspend_3v, gpio_third_clear, codec_sdata_in} = '0;
		{thermal_alarm_n, rtc_alarm_irq_n, ce} = 3'h7;
		gpio_transition    = 16'h0000;
		gpio_pme_enable    = 16'hFFFF;
		gpio_dir_input     = 16'hFFFF;
		retrigger_activity = 7'h00;
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		rchk(IDX_LOAD, 32'h0);
		rchk(IDX_CTRL, 32'h0);
		apb(1'h1, IDX_LOAD, 8'hA5);
		rchk(IDX_LOAD, 32'hA5);
		apb(1'h1, IDX_CTRL, 8'h5A);
		rchk(IDX_CTRL, 32'h5A);
		apb(1'h1, IDX_MIRROR, 8'hFF);
		rchk(IDX_MIRROR, 32'h0);
		apb(1'h0, 8'h00, 8'h00);
		`CHK({e, r}, 33'h100000000)
		$display("Test registers done");
		suspend_3v <= 1'h1;
		apb(1'h1, IDX_CFG, 8'h1C);
		for (i = 0; i < 5; i++)
		begin
			fire(ev[i]);
			rchk(IDX_MIRROR, 32'h1 << ev[i]);
			rchk(IDX_MIRROR, 32'h1 << ev[i]);
			`CHK({top_event_status, system_mgmt_interrupt}, 2'h3)
			rchk(IDX_TWIN, 32'h1 << ev[i]);
			rchk(IDX_MIRROR, 32'h0);
			`CHK(top_event_status, 1'h0)
		end
		apb(1'h1, IDX_CFG, 8'h00);
		suspend_3v <= 1'h0;
		for (i = 0; i < 5; i++)
		begin
			fire(ev[i]);
			rchk(IDX_TWIN, (ev[i] == 3) ? 32'h8 : 32'h0);
		end
		suspend_3v <= 1'h1;
		apb(1'h1, IDX_CFG, 8'h20);
		fire(1);
		fire(7);
		rchk(IDX_TWIN, 32'h0);
		apb(1'h1, IDX_CFG, 8'h00);
		gpio_dir_input <= 16'h0000;
		fire(7);
		rchk(IDX_MIRROR, 32'h0);
		gpio_dir_input <= 16'hFFFF;
		fire(7);
		rchk(IDX_TWIN, 32'h80);
		rchk(IDX_MIRROR, 32'h80);
		gpio_third_clear <= 1'h1;
		@(posedge pclk);
		gpio_third_clear <= 1'h0;
		rchk(IDX_MIRROR, 32'h0);
		$display("Test events done");
		tmr(8'h88, 8'h02, 8'h01);
		wait_exp(40);
		`CHK(n >= 4 && n <= 12, 1'h1)
		`CHK(system_mgmt_interrupt, 1'h1)
		rchk(IDX_TOP, 32'h10200);
		@(posedge pclk);
		retrigger_activity <= 7'h08;
		@(posedge pclk);
		retrigger_activity <= 7'h00;
		wait_exp(40);
		`CHK(n, 40)
		apb(1'h1, IDX_LOAD, 8'h02);
		wait_exp(40);
		`CHK(n >= 4 && n <= 12, 1'h1)
		// Clock enable low must freeze the loaded timer and its prescaler
		tmr(8'h80, 8'h02, 8'h01);
		@(posedge pclk);
		ce <= 1'h0;
		repeat (40) @(posedge pclk);
		`CHK(top_timer1_status, 1'h0)
		ce <= 1'h1;
		wait_exp(40);
		`CHK(n >= 4 && n <= 12, 1'h1)
		tmr(8'h80, 8'h01, 8'h03);
		wait_exp(1100);
		`CHK(n >= 1016 && n <= 1032, 1'h1)
		tmr(8'h00, 8'h02, 8'h01);
		wait_exp(9000);
		`CHK(n >= 4000 && n <= 8010, 1'h1)
		tmr(8'hF8, 8'h01, 8'h02);
		retrigger_activity <= 7'h7F;
		wait_exp(40);
		retrigger_activity <= 7'h00;
		`CHK(n, 40)
		$display("Test timer done");
		// Reloads every third cycle outpace a four-cycle tick, so only a disabled source expires
		for (k = 0; k < 8; k++)
		begin
			i = 3 + k % 4;
			tmr(8'h80 | (8'h01 << ((k < 4) ? i : 9 - i)), 8'h03, 8'h01);
			for (j = 0; j < 30; j++)
			begin
				@(posedge pclk);
				retrigger_activity <= (j % 3 == 0) ? 7'h01 << i : 7'h00;
			end
			`CHK(top_timer1_status, k >= 4)
			wait_exp(20);
			`CHK(top_timer1_status, 1'h1)
		end
		$display("Test retrigger done");
		give_verdict();
	end
endmodule
`default_nettype wire
